// ==== include/gpa_pkg.sv ====
// Package of constants and types for the eight-bit port A block
package gpa_pkg;
	// ========================================
	// Register byte offsets
	localparam logic [7:0] pin_levels_off    = 8'h00;
	localparam logic [7:0] output_latch_off  = 8'h04;
	localparam logic [7:0] direction_off     = 8'h08;
	localparam logic [7:0] analog_ctl_off    = 8'h0c;
	localparam logic [7:0] comparator_ctl_off = 8'h10;
	localparam logic [7:0] config_off        = 8'h14;
	// ========================================
	// Reset values
	localparam logic [7:0] direction_rst     = 8'hff;
	localparam logic [7:0] latch_rst         = 8'h00;
	localparam logic [3:0] analog_cfg_rst    = 4'h0;
	localparam logic [2:0] comparator_rst    = 3'h7;
	localparam logic       osc_pins_rst      = 1'b1;
	// ========================================
	// Field positions
	localparam int         osc_lo_bit        = 6;
	localparam int         osc_hi_bit        = 7;
	localparam int         open_drain_bit    = 4;
	localparam int         ref_out_bit       = 2;
	localparam int         comp2_out_bit     = 5;
	localparam int         comp_mode_w       = 3;
	// Analog select: codes at or above this leave bits 0-3 and 5 digital
	localparam logic [3:0] all_digital_code  = 4'h7;
	// Comparator mode that routes both outputs to pins
	localparam logic [2:0] comp_out_mode     = 3'h5;
	typedef enum logic {gpa_idle, gpa_access} gpa_phase_e;
endpackage : gpa_pkg

// ==== include/gpa_sync_if.sv ====
// Interface carrying raw and synchronised pin levels
`timescale 1ns/1ps
`default_nettype none
interface gpa_sync_if;
	logic [7:0] raw;
	logic [7:0] synced;
	modport top (output raw, input synced);
	modport sync (input raw, output synced);
endinterface : gpa_sync_if
`default_nettype wire

// ==== sim/gpa_board.sv ====
// Board model: pins follow the port drivers, else the bench level
`timescale 1ns/1ps
`default_nettype none
module gpa_board (
	// Port side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	// Bench side
	input  wire logic [7:0] ext,
	output logic      [7:0] pin_in
);
	// Released pins show ext, not a stale driven value
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule : gpa_board
`default_nettype wire

// ==== sim/gpa_port_chk.sv ====
// Port-level assertions for the port A block
`timescale 1ns/1ps
`default_nettype none
module gpa_port_chk (
	// Clock, reset, bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Pins and peripherals
	input wire logic [7:0]  pin_in,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe_n,
	input wire logic        timer_zero_external_clock,
	input wire logic [7:0]  analog_select,
	input wire logic        oscillator_pins_owned
);
	// ========================================
	// Assertions
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_acc = psel && penable && !pwrite;
	wire wr_acc = psel && penable && pwrite;
	property p_rst; $rose(presetn) |-> pin_oe_n == 8'hff; endproperty
	a_rst: assert property (p_rst) else $error("pins not inputs after reset");
	property p_od; !pin_oe_n[4] |-> !pin_out[4]; endproperty
	a_od: assert property (p_od) else $error("bit 4 drives high");
	property p_pin;
		rd_acc && paddr == 8'h00 && analog_select == 8'h00 && !oscillator_pins_owned
		&& $stable(pin_in) && pin_in == $past(pin_in, 2) && pin_in == $past(pin_in, 3)
		&& $past(presetn, 4) |-> prdata[7:0] == pin_in;
	endproperty
	a_pin: assert property (p_pin) else $error("pin read wrong");
	property p_tmr;
		$past(presetn) && $past(presetn, 2) |-> timer_zero_external_clock == $past(pin_in[4], 2);
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer clock wrong");
	property p_oscd; oscillator_pins_owned |-> &pin_oe_n[7:6]; endproperty
	a_oscd: assert property (p_oscd) else $error("oscillator pins driven");
	property p_oscr;
		rd_acc && paddr <= 8'h08 && oscillator_pins_owned |-> prdata[7:6] == 2'b00;
	endproperty
	a_oscr: assert property (p_oscr) else $error("oscillator bits not zero");
	property p_ana;
		rd_acc && paddr == 8'h00 && analog_select == 8'h2f |-> (prdata[7:0] & 8'h2f) == 8'h00;
	endproperty
	a_ana: assert property (p_ana) else $error("analog bits not zero");
	property p_dir; wr_acc && paddr == 8'h08 |=> pin_oe_n[1:0] == $past(pwdata[1:0]); endproperty
	a_dir: assert property (p_dir) else $error("direction not applied");
	property p_lat;
		wr_acc && (paddr == 8'h00 || paddr == 8'h04) |=> pin_oe_n[0] || pin_out[0] == $past(pwdata[0]);
	endproperty
	a_lat: assert property (p_lat) else $error("latch not driven");
endmodule : gpa_port_chk
bind gpa_port gpa_port_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n), .timer_zero_external_clock(timer_zero_external_clock),
	.analog_select(analog_select), .oscillator_pins_owned(oscillator_pins_owned));
`default_nettype wire

// ==== sim/gpa_port_tb.sv ====
// Self-checking bench for the port A block
`timescale 1ns/1ps
`default_nettype none
module gpa_port_tb;
	// ========================================
	// Stimulus and wiring
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, c1 = 0, c2 = 0, cref = 0;
	logic [7:0]  paddr = 8'h00, ext = 8'h00, pin_in, pin_out, pin_oe_n;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, last_err = 0;
	int          err_count = 0, checks_done = 0, cyc = 0;
	always #12.5 pclk = ~pclk;
	gpa_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .first_comparator_output(c1),
		.second_comparator_output(c2), .comparator_reference_enable(cref),
		.timer_zero_external_clock(), .slave_select_in(), .low_voltage_detect_input(),
		.analog_select(), .oscillator_pins_owned());
	gpa_board brd (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		last_err = pslverr;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		apb(1, a, {24'h0, d}, r);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(0, a, 32'h0, r);
		chk(r, exp);
	endtask : rd
	// Pins pass two sync flops before a read sees them
	task settle; repeat (3) @(posedge pclk); endtask : settle
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	// ========================================
	// Scenarios
	task t_reset;
		rd(8'h08, 32'h3f);
		rd(8'h04, 32'h00);
		ext <= 8'hff;
		settle;
		rd(8'h00, 32'h10);
		$display("reset test done");
	endtask : t_reset
	task t_out;
		wr(8'h14, 8'h00); wr(8'h0c, 8'h07); wr(8'h08, 8'h00); wr(8'h00, 8'ha5);
		rd(8'h04, 32'ha5);
		ext <= 8'h00;
		settle;
		rd(8'h00, 32'ha5);
		wr(8'h04, 8'h5e);
		settle;
		rd(8'h00, 32'h4e);
		c2 <= 1; cref <= 1;
		wr(8'h10, 8'h05);
		settle;
		rd(8'h00, 32'h6a);
		$display("output test done");
	endtask : t_out
	task t_in;
		c2 <= 0; cref <= 0;
		wr(8'h10, 8'h07); wr(8'h08, 8'hff); ext <= 8'h3c;
		settle;
		rd(8'h00, 32'h3c);
		wr(8'h0c, 8'h00);
		rd(8'h00, 32'h10);
		wr(8'h14, 8'h01); wr(8'h04, 8'hff);
		rd(8'h04, 32'h3f);
		chk({31'h0, last_err}, 32'h0);
		rd(8'h18, 32'h00);
		// Unmapped offset answers with an error, mapped ones do not
		chk({31'h0, last_err}, 32'h1);
		$display("input test done");
	endtask : t_in
	// Cut a hang short
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset;
		t_out;
		t_in;
		give_verdict;
	end
endmodule : gpa_port_tb
`default_nettype wire

// ==== src/gpa_port.sv ====
// Eight-bit general purpose port A with APB register access
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpa_port (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Port pins
	input  wire logic [7:0]  pin_in,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe_n,
	// Peripheral connections
	input  wire logic        first_comparator_output,
	input  wire logic        second_comparator_output,
	input  wire logic        comparator_reference_enable,
	output logic             timer_zero_external_clock,
	output logic             slave_select_in,
	output logic             low_voltage_detect_input,
	output logic      [7:0]  analog_select,
	output logic             oscillator_pins_owned
);
	// ========================================
	// State
	typedef struct packed {
		logic [7:0]  latch;
		logic [7:0]  direction;
		logic [3:0]  analog_cfg;
		logic [2:0]  comp_mode;
		logic        osc_pins;
		logic [31:0] rdata;
	} gpa_state_s;
	gpa_state_s st_q;
	gpa_state_s st_d;

	gpa_sync_if sif ();
	logic [7:0] gpio_mask;
	logic [7:0] analog_mask;
	logic       comp_outs;
	logic [7:0] periph_drive_en;
	logic [7:0] periph_val;

	// Mask for bits usable as I/O given the oscillator setting
	function automatic logic [7:0] osc_mask(input logic own);
		osc_mask = own ? 8'h3f : 8'hff;
	endfunction : osc_mask

	// Decode of pins selected analog; reset code keeps bits 0-3 and 5 analog
	function automatic logic [7:0] analog_decode(input logic [3:0] cfg);
		analog_decode = (cfg >= gpa_pkg::all_digital_code) ? 8'h00 : 8'h2f;
	endfunction : analog_decode

	// ========================================
	// Pin synchroniser
	assign sif.raw = pin_in;
	gpa_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.lv      (sif.sync)
	);

	// ========================================
	// Pin muxing
	assign gpio_mask   = osc_mask(st_q.osc_pins);
	assign analog_mask = analog_decode(st_q.analog_cfg);
	assign comp_outs   = (st_q.comp_mode == gpa_pkg::comp_out_mode);
	always_comb begin
		periph_drive_en = 8'h00;
		periph_val      = 8'h00;
		// Comparator outputs take over their pins
		if (comp_outs) begin
			periph_drive_en[gpa_pkg::open_drain_bit] = 1'b1;
			periph_val[gpa_pkg::open_drain_bit]      = first_comparator_output;
			periph_drive_en[gpa_pkg::comp2_out_bit]  = 1'b1;
			periph_val[gpa_pkg::comp2_out_bit]       = second_comparator_output;
		end
		// Reference voltage is analog; the digital driver steps aside
		if (comparator_reference_enable) begin
			periph_drive_en[gpa_pkg::ref_out_bit] = 1'b1;
			periph_val[gpa_pkg::ref_out_bit]      = 1'b0;
		end
	end

	// Drivers, built per bit
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			logic drv_en;
			logic drv_val;
			always_comb begin
				if (!gpio_mask[gi]) begin
					drv_en  = 1'b0;
					drv_val = 1'b0;
				end else if (periph_drive_en[gi]) begin
					drv_en  = !(gi == gpa_pkg::ref_out_bit);
					drv_val = periph_val[gi];
				end else begin
					// Analog pins still obey direction; software must keep them inputs
					drv_en  = !st_q.direction[gi];
					drv_val = st_q.latch[gi];
				end
				// Open-drain bit only pulls low, never drives high
				if (gi == gpa_pkg::open_drain_bit) begin
					drv_en  = drv_en && !drv_val;
					drv_val = 1'b0;
				end
			end
			assign pin_oe_n[gi] = !drv_en;
			assign pin_out[gi]  = drv_val;
		end
	endgenerate

	// ========================================
	// Peripheral inputs taken from synchronised levels; analog select and oscillator ownership taken from registers
	assign timer_zero_external_clock = sif.synced[gpa_pkg::open_drain_bit];
	assign slave_select_in           = sif.synced[gpa_pkg::comp2_out_bit];
	assign low_voltage_detect_input  = sif.synced[gpa_pkg::comp2_out_bit];
	assign analog_select             = analog_mask;
	assign oscillator_pins_owned     = st_q.osc_pins;

	// ========================================
	// APB register file
	logic       wr_en;
	logic [7:0] pin_view;
	assign wr_en    = psel && penable && pwrite;
	// Analog pins read zero; pin reads after two flops
	assign pin_view = sif.synced & ~analog_mask & gpio_mask;

	always_comb begin
		st_d = st_q;
		if (wr_en) begin
			unique case (paddr)
				gpa_pkg::pin_levels_off:     st_d.latch = pwdata[7:0] & gpio_mask;
				gpa_pkg::output_latch_off:   st_d.latch = pwdata[7:0] & gpio_mask;
				gpa_pkg::direction_off:      st_d.direction = pwdata[7:0] | ~gpio_mask;
				gpa_pkg::analog_ctl_off:     st_d.analog_cfg = pwdata[3:0];
				gpa_pkg::comparator_ctl_off: st_d.comp_mode = pwdata[gpa_pkg::comp_mode_w-1:0];
				gpa_pkg::config_off:         st_d.osc_pins = pwdata[0];
				default: ;
			endcase
		end
		// Oscillator-owned bits hold cleared latch; direction writes set them internally
		st_d.latch     = st_d.latch & gpio_mask;
		st_d.rdata     = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				gpa_pkg::pin_levels_off:     st_d.rdata[7:0] = pin_view;
				gpa_pkg::output_latch_off:   st_d.rdata[7:0] = st_q.latch & gpio_mask;
				gpa_pkg::direction_off:      st_d.rdata[7:0] = st_q.direction & gpio_mask;
				gpa_pkg::analog_ctl_off:     st_d.rdata[3:0] = st_q.analog_cfg;
				gpa_pkg::comparator_ctl_off: st_d.rdata[2:0] = st_q.comp_mode;
				gpa_pkg::config_off:         st_d.rdata[0] = st_q.osc_pins;
				default: ;
			endcase
		end else if (psel && penable) begin
			st_d.rdata = st_q.rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q.latch      <= gpa_pkg::latch_rst;
			st_q.direction  <= gpa_pkg::direction_rst;
			st_q.analog_cfg <= gpa_pkg::analog_cfg_rst;
			st_q.comp_mode  <= gpa_pkg::comparator_rst;
			st_q.osc_pins   <= gpa_pkg::osc_pins_rst;
			st_q.rdata      <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata  = st_q.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(paddr inside {gpa_pkg::pin_levels_off,
		gpa_pkg::output_latch_off, gpa_pkg::direction_off, gpa_pkg::analog_ctl_off,
		gpa_pkg::comparator_ctl_off, gpa_pkg::config_off});
endmodule : gpa_port
`default_nettype wire

// ==== src/gpa_sync.sv ====
// Two-stage synchroniser for the port pin levels
`timescale 1ns/1ps
`default_nettype none
module gpa_sync (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Pin levels
	gpa_sync_if.sync  lv
);
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
	} gpa_sync_s;
	gpa_sync_s st_q;
	gpa_sync_s st_d;

	// ========================================
	// First stage feeds only the second
	always_comb begin
		st_d.first  = lv.raw;
		st_d.second = st_q.first;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign lv.synced = st_q.second;
endmodule : gpa_sync
`default_nettype wire
